// ### design/prsic_consts.svh
// constants for the reset sequencer and system interrupt block
`ifndef PRSIC_CONSTS_SVH
`define PRSIC_CONSTS_SVH
`define PRSIC_CLK_MHZ         200
`define PRSIC_ADDR_CTRL       32'h0000_0000
`define PRSIC_ADDR_MASK       32'h0000_0004
`define PRSIC_ADDR_STATUS     32'h0000_0008
`define PRSIC_ADDR_SYS        32'h0000_000c
`define PRSIC_CTRL_SOFT_RST   0
`define PRSIC_CTRL_CORE_RST   1
`define PRSIC_CTRL_MAC_RST    2
`define PRSIC_MASK_SW_REQ     0
`define PRSIC_MASK_HARD_EN    1
`define PRSIC_ST_SW           0
`define PRSIC_ST_HARD         1
`define PRSIC_ERR_LSB         8
`define PRSIC_ERR_W           4
`define PRSIC_MASK_RESET      16'h0000
`define PRSIC_DEGLITCH_NS     1000
`define PRSIC_DEGLITCH_CYC    ((`PRSIC_DEGLITCH_NS * `PRSIC_CLK_MHZ + 999) / 1000)
`define PRSIC_SUBRST_NS       1200
`define PRSIC_SUBRST_CYC      ((`PRSIC_SUBRST_NS * `PRSIC_CLK_MHZ) / 1000)
`define PRSIC_HW_INIT_MS      50
`define PRSIC_SW_INIT_MS      10
`define PRSIC_HW_REFCLK_MS    70
`define PRSIC_SW_REFCLK_MS    25
`define PRSIC_STRAP_CYC       8
`define PRSIC_PIN_MIN_NS      10000
`define PRSIC_PIN_MIN_CYC     ((`PRSIC_PIN_MIN_NS * `PRSIC_CLK_MHZ) / 1000)
`endif

// ### design/prsic_pkg.sv
// types for the reset sequencer and system interrupt block
package prsic_pkg;
    typedef enum logic [2:0] {
        PRSIC_ST_HOLD   = 3'b000,
        PRSIC_ST_STRAP  = 3'b001,
        PRSIC_ST_INIT   = 3'b011,
        PRSIC_ST_RUN    = 3'b010
    } prsic_seq_t;

    typedef struct packed {
        logic [31:0] haddr;
        logic        hwrite;
        logic        hsel;
        logic        act;
    } prsic_aph_t;

    typedef struct packed {
        prsic_seq_t  seq;
        logic [31:0] init_cnt;
        logic [31:0] ref_cnt;
        logic [7:0]  glitch_cnt;
        logic        pin_rst;
        logic        soft_run;
        logic [7:0]  core_cnt;
        logic [7:0]  mac_cnt;
        logic [15:0] mask;
        logic        sw_lh;
        logic        hard_lh;
        logic [3:0]  err_lh;
        logic        ready;
        logic [3:0]  straps;
        prsic_aph_t  aph;
        logic [31:0] hrdata;
        logic        irq_n;
        logic        io_oe;
        logic        ref_en;
        logic        core_rst;
        logic        mac_rst;
        logic        logic_rst;
        logic        osc_en;
        logic        pll_en;
    } prsic_state_t;
endpackage

// ### design/prsic_top.sv
// reset sequencer and system interrupt logic with ahb-lite register slave
`timescale 1ns/1ps
`include "prsic_consts.svh"
module prsic_top #(
    parameter int unsigned HW_INIT_CYC = `PRSIC_HW_INIT_MS * `PRSIC_CLK_MHZ * 1000,
    parameter int unsigned SW_INIT_CYC = `PRSIC_SW_INIT_MS * `PRSIC_CLK_MHZ * 1000,
    parameter int unsigned HW_REF_CYC  = `PRSIC_HW_REFCLK_MS * `PRSIC_CLK_MHZ * 1000,
    parameter int unsigned SW_REF_CYC  = `PRSIC_SW_REFCLK_MS * `PRSIC_CLK_MHZ * 1000
) (
    input  wire logic        hclk,          // system clock
    input  wire logic        hresetn,       // async reset, active low
    input  wire logic        hsel,          // slave select
    input  wire logic [31:0] haddr,         // address
    input  wire logic [1:0]  htrans,        // transfer type
    input  wire logic        hwrite,        // write strobe
    input  wire logic [2:0]  hsize,         // transfer size
    input  wire logic [31:0] hwdata,        // write data
    input  wire logic        hready,        // bus ready
    output logic [31:0]      hrdata,        // read data
    output logic             hreadyout,     // slave ready
    output logic             hresp,         // response, always okay
    input  wire logic        reset_pin_n,   // external reset pin, active low
    input  wire logic        power_good,    // all supplies above threshold
    input  wire logic        osc_stable,    // crystal started and stable
    input  wire logic [3:0]  strap_in,      // configuration strap pin levels
    input  wire logic [3:0]  sys_err,       // system error condition pulses
    output logic             irq_n,         // host alert, active low
    output logic             io_oe,         // i/o pins in functional mode
    output logic             ref_clk_en,    // ref_clock_output allowed to run
    output logic             core_rst,      // phy core held in reset
    output logic             mac_rst,       // mac port held in reset
    output logic             mac_out_zero,  // force mac-side outputs low
    output logic             logic_rst,     // internal logic held in reset
    output logic             osc_en,        // oscillator enable
    output logic             pll_en,        // pll enable
    output logic [3:0]       straps         // captured strap levels
);

    prsic_pkg::prsic_state_t s_q, s_d;
    logic [31:0] wval;
    logic        rd_acc;
    logic        start_hw;
    logic        start_sw;

    // ********************************************************************
    // register map decode
    // ********************************************************************
    function automatic logic [1:0] addr_idx(input logic [31:0] a);
        if (a == `PRSIC_ADDR_CTRL) begin
            return 2'h0;
        end else if (a == `PRSIC_ADDR_MASK) begin
            return 2'h1;
        end else if (a == `PRSIC_ADDR_STATUS) begin
            return 2'h2;
        end else begin
            return 2'h3;
        end
    endfunction

    function automatic logic addr_hit(input logic [31:0] a);
        return (a == `PRSIC_ADDR_CTRL) || (a == `PRSIC_ADDR_MASK) ||
               (a == `PRSIC_ADDR_STATUS) || (a == `PRSIC_ADDR_SYS);
    endfunction

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        s_d      = s_q;
        wval     = hwdata;
        rd_acc   = 1'b0;
        start_hw = 1'b0;
        start_sw = 1'b0;

        // deglitch of the reset pin; only a low of 1 us counts
        if (reset_pin_n) begin
            s_d.glitch_cnt = 8'h00;
            s_d.pin_rst    = 1'b0;
        end else if (s_q.glitch_cnt >= 8'(`PRSIC_DEGLITCH_CYC - 1)) begin
            s_d.pin_rst = 1'b1;
        end else begin
            s_d.glitch_cnt = s_q.glitch_cnt + 8'h01;
        end

        // bus data phase
        s_d.aph.act = 1'b0;
        if (s_q.aph.act && s_q.aph.hsel) begin
            if (s_q.aph.hwrite) begin
                if (addr_idx(s_q.aph.haddr) == 2'h0) begin
                    if (wval[`PRSIC_CTRL_SOFT_RST] && s_q.seq == prsic_pkg::PRSIC_ST_RUN) begin
                        start_sw = 1'b1;
                    end
                    if (wval[`PRSIC_CTRL_CORE_RST] && s_q.core_cnt == 8'h00) begin
                        s_d.core_cnt = 8'(`PRSIC_SUBRST_CYC);
                    end
                    if (wval[`PRSIC_CTRL_MAC_RST] && s_q.mac_cnt == 8'h00) begin
                        s_d.mac_cnt = 8'(`PRSIC_SUBRST_CYC);
                    end
                end else if (addr_idx(s_q.aph.haddr) == 2'h1) begin
                    s_d.mask = wval[15:0];
                end
            end else if (addr_idx(s_q.aph.haddr) == 2'h2) begin
                rd_acc = 1'b1;
            end
        end

        // sub-resets count down and self clear; registers untouched
        if (s_q.core_cnt != 8'h00) begin
            s_d.core_cnt = s_q.core_cnt - 8'h01;
        end
        if (s_q.mac_cnt != 8'h00) begin
            s_d.mac_cnt = s_q.mac_cnt - 8'h01;
        end

        // status flags: read clears sw and hard flags, error flags hold until hard reset; a new event in the same cycle wins
        if (rd_acc) begin
            s_d.sw_lh   = 1'b0;
            s_d.hard_lh = 1'b0;
        end
        if (s_q.mask[`PRSIC_MASK_SW_REQ]) begin
            s_d.sw_lh = 1'b1;
        end
        s_d.err_lh = s_q.err_lh | sys_err;

        // reset sequencer
        start_hw = s_q.pin_rst || !power_good;
        case (s_q.seq)
            prsic_pkg::PRSIC_ST_HOLD: begin
                s_d.init_cnt = 32'h0;
                if (!start_hw) begin
                    s_d.seq = prsic_pkg::PRSIC_ST_STRAP;
                end
            end
            prsic_pkg::PRSIC_ST_STRAP: begin
                s_d.init_cnt = s_q.init_cnt + 32'h1;
                if (s_q.init_cnt == 32'(`PRSIC_STRAP_CYC - 1)) begin
                    s_d.straps   = strap_in;
                    s_d.io_oe    = 1'b1;
                    s_d.init_cnt = 32'h0;
                    s_d.seq      = prsic_pkg::PRSIC_ST_INIT;
                end
            end
            prsic_pkg::PRSIC_ST_INIT: begin
                s_d.init_cnt = s_q.init_cnt + 32'h1;
                if (s_q.init_cnt >= (s_q.soft_run ? SW_INIT_CYC : HW_INIT_CYC) - 32'h1) begin
                    s_d.logic_rst = 1'b0;
                    s_d.ready     = 1'b1;
                    s_d.seq       = prsic_pkg::PRSIC_ST_RUN;
                    if (!s_q.soft_run && s_q.mask[`PRSIC_MASK_HARD_EN]) begin
                        s_d.hard_lh = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase
        if (start_sw) begin
            s_d.seq       = prsic_pkg::PRSIC_ST_STRAP;
            s_d.soft_run  = 1'b1;
            s_d.init_cnt  = 32'h0;
            s_d.ref_cnt   = 32'h0;
            s_d.ref_en    = 1'b0;
            s_d.io_oe     = 1'b0;
            s_d.logic_rst = 1'b1;
            s_d.ready     = 1'b0;
        end
        if (start_hw) begin
            s_d.seq       = prsic_pkg::PRSIC_ST_HOLD;
            s_d.soft_run  = 1'b0;
            s_d.ref_cnt   = 32'h0;
            s_d.ref_en    = 1'b0;
            s_d.io_oe     = 1'b0;
            s_d.logic_rst = 1'b1;
            s_d.ready     = 1'b0;
            s_d.mask      = `PRSIC_MASK_RESET;
            s_d.sw_lh     = 1'b0;
            s_d.err_lh    = 4'h0;
            s_d.core_cnt  = 8'h00;
            s_d.mac_cnt   = 8'h00;
        end

        // ref clock held low for its own delay after release
        if (!start_hw && !start_sw && !s_q.ref_en && s_q.seq != prsic_pkg::PRSIC_ST_HOLD) begin
            s_d.ref_cnt = s_q.ref_cnt + 32'h1;
            if (s_q.ref_cnt >= (s_q.soft_run ? SW_REF_CYC : HW_REF_CYC) - 32'h1) begin
                s_d.ref_en = 1'b1;
            end
        end

        // outputs
        s_d.core_rst = s_d.logic_rst || (s_d.core_cnt != 8'h00);
        s_d.mac_rst  = s_d.core_rst || (s_d.mac_cnt != 8'h00);
        s_d.irq_n    = !((s_d.sw_lh && s_d.mask[`PRSIC_MASK_SW_REQ]) ||
                         (s_d.hard_lh && s_d.mask[`PRSIC_MASK_HARD_EN]) ||
                         |(s_d.err_lh & s_d.mask[`PRSIC_ERR_LSB +: `PRSIC_ERR_W]));
        s_d.osc_en   = (s_d.seq == prsic_pkg::PRSIC_ST_INIT) ||
                       (s_d.seq == prsic_pkg::PRSIC_ST_RUN);
        s_d.pll_en   = s_d.io_oe && osc_stable;

        // read data for the next data phase
        s_d.hrdata = 32'h0;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (addr_idx(haddr) == 2'h0) begin
                s_d.hrdata = {29'h0, (s_q.mac_cnt != 8'h00), (s_q.core_cnt != 8'h00),
                              (s_q.seq != prsic_pkg::PRSIC_ST_RUN)};
            end else if (addr_idx(haddr) == 2'h1) begin
                s_d.hrdata = {16'h0, s_q.mask};
            end else if (addr_idx(haddr) == 2'h2) begin
                s_d.hrdata = {20'h0, s_d.err_lh, 6'h0, s_d.hard_lh, s_d.sw_lh};
            end else if (addr_hit(haddr)) begin
                s_d.hrdata = {27'h0, s_q.straps, s_q.ready};
            end
        end
        s_d.aph.act    = hsel && hready && htrans[1];
        s_d.aph.hsel   = hsel;
        s_d.aph.hwrite = hwrite;
        s_d.aph.haddr  = haddr;
    end

    // ********************************************************************
    // state register
    // ********************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q           <= '0;
            s_q.seq       <= prsic_pkg::PRSIC_ST_HOLD;
            s_q.irq_n     <= 1'b1;
            s_q.core_rst  <= 1'b1;
            s_q.mac_rst   <= 1'b1;
            s_q.logic_rst <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata       = s_q.hrdata;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign irq_n        = s_q.irq_n;
    assign io_oe        = s_q.io_oe;
    assign ref_clk_en   = s_q.ref_en;
    assign core_rst     = s_q.core_rst;
    assign mac_rst      = s_q.mac_rst;
    assign mac_out_zero = s_q.core_rst;
    assign logic_rst    = s_q.logic_rst;
    assign osc_en       = s_q.osc_en;
    assign pll_en       = s_q.pll_en;
    assign straps       = s_q.straps;

endmodule // prsic_top

// ### test/prsic_checker.sv
// port assertions for the reset sequencer and system irq block
`timescale 1ns/1ps
module prsic_checker #(
    parameter int unsigned HW_INIT_CYC = 100
) (
    input wire logic        hclk,         // clock
    input wire logic        hresetn,      // reset, active low
    input wire logic        hsel,         // select
    input wire logic [31:0] haddr,        // address
    input wire logic [1:0]  htrans,       // transfer type
    input wire logic        hwrite,       // write
    input wire logic [31:0] hwdata,       // write data
    input wire logic        hreadyout,    // ready
    input wire logic        reset_pin_n,  // reset pin
    input wire logic        power_good,   // supplies good
    input wire logic        irq_n,        // alert
    input wire logic        io_oe,        // pins functional
    input wire logic        ref_clk_en,   // ref clock on
    input wire logic        core_rst,     // core reset
    input wire logic        mac_rst,      // mac reset
    input wire logic        mac_out_zero, // mac outputs low
    input wire logic        logic_rst     // logic reset
);
    logic [31:0] lo_q, rel_q, wa_q;
    logic [7:0]  cr_q, mr_q;
    logic        wr_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lo_q <= 32'h0;
            rel_q <= 32'h0;
            wa_q <= 32'h0;
            cr_q <= 8'h0;
            mr_q <= 8'h0;
            wr_q <= 1'b0;
        end else begin
            lo_q <= reset_pin_n ? 32'h0 : lo_q + 32'h1;
            rel_q <= (logic_rst && reset_pin_n && power_good) ? rel_q + 32'h1 : 32'h0;
            cr_q <= core_rst ? cr_q + 8'h1 : 8'h0;
            mr_q <= mac_rst ? mr_q + 8'h1 : 8'h0;
            if (hreadyout) begin
                wr_q <= hsel && htrans[1] && hwrite;
                wa_q <= haddr;
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_mac_zero; core_rst |-> mac_out_zero && mac_rst; endproperty
    property p_sw_alert; wr_q && wa_q == 32'h4 && hwdata[0] |-> ##[1:3] !irq_n; endproperty
    property p_pin_rst; lo_q == 32'hd2 |-> logic_rst && !io_oe && !ref_clk_en; endproperty
    property p_glitch;
        lo_q > 32'h0 && lo_q < 32'h96 && power_good && !$past(logic_rst) |-> !logic_rst;
    endproperty
    property p_core_len;
        $fell(core_rst) && !$past(logic_rst) |-> $past(cr_q) inside {[8'hef:8'hf0]};
    endproperty
    property p_mac_len;
        $fell(mac_rst) && !$past(logic_rst) |-> $past(mr_q) inside {[8'hef:8'hf0]};
    endproperty
    property p_io_order; $rose(io_oe) |-> logic_rst; endproperty
    property p_init_time; logic_rst |-> rel_q < HW_INIT_CYC + 32'h10; endproperty
    a_mac_zero: assert property (p_mac_zero) else $error("mac outputs not low");
    a_sw_alert: assert property (p_sw_alert) else $error("no software alert");
    a_pin_rst: assert property (p_pin_rst) else $error("pin reset not taken");
    a_glitch: assert property (p_glitch) else $error("short pulse reset");
    a_core_len: assert property (p_core_len) else $error("core pulse length");
    a_mac_len: assert property (p_mac_len) else $error("mac pulse length");
    a_io_order: assert property (p_io_order) else $error("pins enabled late");
    a_init_time: assert property (p_init_time) else $error("init too long");
    c_core: cover property ($fell(core_rst));
    c_alert: cover property ($fell(irq_n));
    c_pin: cover property (lo_q == 32'hd2);
    c_power: cover property ($fell(power_good));
endmodule // prsic_checker

// ### test/prsic_board.sv
// board model: reset pin, supplies, oscillator and error sources
`timescale 1ns/1ps
module prsic_board (
    input  wire logic       hclk,        // clock
    output logic            reset_pin_n, // reset pin
    output logic            power_good,  // supplies good
    output logic            osc_stable,  // crystal stable
    output logic [3:0]      sys_err      // error pulses
);
    initial begin
        reset_pin_n = 1'b1;
        power_good = 1'b1;
        osc_stable = 1'b1;
        sys_err = 4'h0;
    end
    task automatic pin_low(input int n);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge hclk);
        reset_pin_n <= 1'b1;
    endtask
    task automatic power_dip(input int n);
        power_good <= 1'b0;
        repeat (n) @(posedge hclk);
        power_good <= 1'b1;
    endtask
    task automatic set_osc(input logic v);
        osc_stable <= v;
    endtask
    task automatic err_pulse(input logic [3:0] e);
        sys_err <= e;
        @(posedge hclk);
        sys_err <= 4'h0;
    endtask
endmodule // prsic_board

// ### test/test_phy_reset_and_system_irq_ctrl.sv
// self-checking bench for the reset sequencer and system irq block
`timescale 1ns/1ps
`include "prsic_consts.svh"
module test_phy_reset_and_system_irq_ctrl;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_q;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        reset_pin_n, power_good, osc_stable, irq_n, io_oe, ref_clk_en;
    logic        core_rst, mac_rst, mac_out_zero, logic_rst, osc_en, pll_en;
    logic [3:0]  strap_in, sys_err, straps, sv;
    logic [31:0] exp_q[$];
    int          bad_count, n_compared, cyc, seed, i;
    assign hready = hreadyout;
    prsic_top #(.HW_INIT_CYC(100), .SW_INIT_CYC(50), .HW_REF_CYC(140), .SW_REF_CYC(60))
    prsic_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_pin_n(reset_pin_n),
        .power_good(power_good), .osc_stable(osc_stable), .strap_in(strap_in),
        .sys_err(sys_err), .irq_n(irq_n), .io_oe(io_oe), .ref_clk_en(ref_clk_en),
        .core_rst(core_rst), .mac_rst(mac_rst), .mac_out_zero(mac_out_zero),
        .logic_rst(logic_rst), .osc_en(osc_en), .pll_en(pll_en), .straps(straps));
    prsic_board prsic_board_i (.hclk(hclk), .reset_pin_n(reset_pin_n),
        .power_good(power_good), .osc_stable(osc_stable), .sys_err(sys_err));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_compared++;
        if (seen !== expd) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        while (logic_rst !== 1'b0 && k < 1000) begin
            @(posedge hclk);
            k++;
        end
        check(32'(logic_rst), 32'h0);
    endtask
    always @(posedge hclk) begin
        if (rd_q && hreadyout) check(hrdata, exp_q.pop_front());
        if (hreadyout) rd_q <= hsel && htrans[1] && !hwrite;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        seed = 32'heae2;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        sv = 4'($random(seed));
        strap_in = sv;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        wait_ready();
        rd(`PRSIC_ADDR_SYS, {27'h0, sv, 1'b1});
        check(32'(straps), 32'(sv));
        check(32'(osc_en), 32'h1);
        check(32'(pll_en), 32'h1);
        prsic_board_i.set_osc(1'b0);
        repeat (2) @(posedge hclk);
        check(32'(pll_en), 32'h0);
        prsic_board_i.set_osc(1'b1);
        repeat (2) @(posedge hclk);
        check(32'(pll_en), 32'h1);
        bus(1'b1, 32'h20, $random(seed));
        rd(32'h20, 32'h0);
        bus(1'b1, `PRSIC_ADDR_MASK, 32'h1);
        repeat (3) @(posedge hclk);
        check(32'(irq_n), 32'h0);
        rd(`PRSIC_ADDR_STATUS, 32'h1);
        bus(1'b1, `PRSIC_ADDR_MASK, 32'h0);
        rd(`PRSIC_ADDR_STATUS, 32'h1);
        rd(`PRSIC_ADDR_STATUS, 32'h0);
        repeat (2) @(posedge hclk);
        check(32'(irq_n), 32'h1);
        prsic_board_i.err_pulse(4'h5);
        repeat (3) @(posedge hclk);
        check(32'(irq_n), 32'h1);
        rd(`PRSIC_ADDR_STATUS, 32'h500);
        rd(`PRSIC_ADDR_STATUS, 32'h500);
        bus(1'b1, `PRSIC_ADDR_MASK, 32'hf00);
        repeat (3) @(posedge hclk);
        check(32'(irq_n), 32'h0);
        bus(1'b1, `PRSIC_ADDR_MASK, 32'h2);
        repeat (3) @(posedge hclk);
        check(32'(irq_n), 32'h1);
        prsic_board_i.pin_low(100);
        repeat (5) @(posedge hclk);
        check(32'(logic_rst), 32'h0);
        rd(`PRSIC_ADDR_STATUS, 32'h500);
        for (i = 1; i < 3; i++) begin
            bus(1'b1, `PRSIC_ADDR_CTRL, 32'h1 << i);
            rd(`PRSIC_ADDR_CTRL, 32'h1 << i);
            repeat (`PRSIC_SUBRST_CYC) @(posedge hclk);
            rd(`PRSIC_ADDR_CTRL, 32'h0);
            rd(`PRSIC_ADDR_MASK, 32'h2);
        end
        sv = 4'($random(seed));
        strap_in <= sv;
        bus(1'b1, `PRSIC_ADDR_CTRL, 32'h1);
        repeat (4) @(posedge hclk);
        check(32'(logic_rst), 32'h1);
        check(32'(ref_clk_en), 32'h0);
        check(32'(osc_en), 32'h0);
        check(32'(pll_en), 32'h0);
        wait_ready();
        rd(`PRSIC_ADDR_SYS, {27'h0, sv, 1'b1});
        check(32'(straps), 32'(sv));
        repeat (40) @(posedge hclk);
        check(32'(ref_clk_en), 32'h1);
        prsic_board_i.pin_low(`PRSIC_PIN_MIN_CYC + 20);
        check(32'(ref_clk_en), 32'h0);
        repeat (20) @(posedge hclk);
        bus(1'b1, `PRSIC_ADDR_MASK, 32'h2);
        wait_ready();
        repeat (3) @(posedge hclk);
        check(32'(irq_n), 32'h0);
        rd(`PRSIC_ADDR_STATUS, 32'h2);
        rd(`PRSIC_ADDR_STATUS, 32'h0);
        repeat (3) @(posedge hclk);
        check(32'(irq_n), 32'h1);
        sv = 4'($random(seed)) | 4'h1;
        prsic_board_i.err_pulse(sv);
        rd(`PRSIC_ADDR_STATUS, {20'h0, sv, 8'h00});
        prsic_board_i.power_dip(4);
        check(32'(logic_rst), 32'h1);
        wait_ready();
        rd(`PRSIC_ADDR_STATUS, 32'h0);
        finish_test();
    end
endmodule // test_phy_reset_and_system_irq_ctrl
bind prsic_top prsic_checker #(.HW_INIT_CYC(HW_INIT_CYC)) prsic_checker_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hreadyout(hreadyout), .reset_pin_n(reset_pin_n),
    .power_good(power_good), .irq_n(irq_n), .io_oe(io_oe), .ref_clk_en(ref_clk_en),
    .core_rst(core_rst), .mac_rst(mac_rst), .mac_out_zero(mac_out_zero),
    .logic_rst(logic_rst));
